//--- rtl/uisl_top.sv
// Interrupt source status, line format control and Avalon-MM register slave of a single-channel UART.
`timescale 1ns/10ps
module uisl_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM register slave.
    input wire logic [uisl_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [uisl_pkg::DATA_W-1:0] writedata,
    output logic [uisl_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // Interrupt sources from the rest of the UART.
    input wire logic receive_line_condition,
    input wire logic receive_data_available,
    input wire logic receive_timeout,
    input wire logic transmit_holding_empty,
    input wire logic modem_change_status,
    input wire logic xoff_detected,
    input wire logic xon_received,
    input wire logic special_char_detected,
    input wire logic flow_line_change,
    // Serial path through the break gate.
    input wire logic tx_serial_in,
    output logic tx_serial_out,
    // Line format and access controls for the rest of the UART.
    output logic divisor_latch_access,
    output logic [3:0] word_length_bits,
    output logic [2:0] stop_half_bits,
    output logic parity_enable,
    output logic parity_even,
    output logic parity_forced,
    output logic parity_forced_value,
    output logic fifo_enable,
    output logic transmit_holding_load,
    output logic [7:0] transmit_holding_data,
    // Interrupt request.
    output logic irq_out
);
    logic ack_reg;
    logic [7:0] line_format_control_reg;
    logic [1:0] config_reg;
    logic [5:0] source_enable_reg;
    logic [uisl_pkg::DATA_W-1:0] readdata_reg;
    logic [uisl_pkg::DATA_W-1:0] readdata_next;
    logic tx_empty_pend_reg;
    logic xoff_pend_reg;
    logic special_pend_reg;
    logic flow_pend_reg;
    logic [7:0] transmit_holding_reg;
    logic thr_load_reg;
    logic take_write;
    logic take_read;
    logic read_status_take;
    logic enhanced;
    logic [7:0] interrupt_source_status;
    uisl_pkg::uisl_code_t code_next;
    logic [7:0] status_snapshot_reg;

    // The bus answers one cycle after the request is seen so read data come from a flop.
    assign waitrequest = (read | write) & ~ack_reg;
    assign take_write = write & ack_reg;
    assign take_read = read & ack_reg;
    assign readdata = readdata_reg;
    assign read_status_take = take_read && address == uisl_pkg::OFS_INT_STATUS;

    // Acknowledge flop, one pulse per request.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        readdata_next = '0;
        unique case (address)
            uisl_pkg::OFS_INT_STATUS: readdata_next[7:0] = interrupt_source_status;
            uisl_pkg::OFS_LINE_FORMAT: readdata_next[7:0] = line_format_control_reg;
            uisl_pkg::OFS_CONFIG: readdata_next[1:0] = config_reg;
            uisl_pkg::OFS_SOURCE_ENABLE: readdata_next[5:0] = source_enable_reg;
            uisl_pkg::OFS_TX_HOLDING: readdata_next[7:0] = transmit_holding_reg;
            default: readdata_next = '0;
        endcase
    end

    // Read data are captured in the waiting cycle and held through the accepting edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            readdata_reg <= '0;
            status_snapshot_reg <= 8'h01;
        end else if (read && !ack_reg) begin
            readdata_reg <= readdata_next;
            status_snapshot_reg <= interrupt_source_status;
        end
    end

    // Software-written control registers.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            line_format_control_reg <= uisl_pkg::LFC_RESET;
            config_reg <= uisl_pkg::CFG_RESET;
            source_enable_reg <= uisl_pkg::EN_RESET;
        end else if (take_write) begin
            if (address == uisl_pkg::OFS_LINE_FORMAT) begin
                line_format_control_reg <= writedata[7:0];
            end
            if (address == uisl_pkg::OFS_CONFIG) begin
                config_reg <= writedata[1:0];
            end
            if (address == uisl_pkg::OFS_SOURCE_ENABLE) begin
                source_enable_reg <= writedata[uisl_pkg::EN_W-1:0];
            end
        end
    end

    // Transmit holding load; the strobe lasts one cycle after the accepting edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            transmit_holding_reg <= 8'h00;
            thr_load_reg <= 1'b0;
        end else begin
            thr_load_reg <= take_write && address == uisl_pkg::OFS_TX_HOLDING;
            if (take_write && address == uisl_pkg::OFS_TX_HOLDING) begin
                transmit_holding_reg <= writedata[7:0];
            end
        end
    end

    assign transmit_holding_load = thr_load_reg;
    assign transmit_holding_data = transmit_holding_reg;

    // Transmit-empty latch; a new empty event wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_empty_pend_reg <= 1'b0;
        end else if (transmit_holding_empty) begin
            tx_empty_pend_reg <= 1'b1;
        end else if ((take_write && address == uisl_pkg::OFS_TX_HOLDING) ||
                     (read_status_take && status_snapshot_reg[5:0] == uisl_pkg::CODE_TXEMPTY)) begin
            tx_empty_pend_reg <= 1'b0;
        end
    end

    // Xoff indication holds until Xon arrives; a fresh Xoff wins over Xon.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            xoff_pend_reg <= 1'b0;
        end else if (xoff_detected) begin
            xoff_pend_reg <= 1'b1;
        end else if (xon_received) begin
            xoff_pend_reg <= 1'b0;
        end
    end

    // Special character and flow change latches clear when their code is read out.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            special_pend_reg <= 1'b0;
            flow_pend_reg <= 1'b0;
        end else begin
            if (special_char_detected) begin
                special_pend_reg <= 1'b1;
            end else if (read_status_take && status_snapshot_reg[5:0] == uisl_pkg::CODE_XOFF) begin
                special_pend_reg <= 1'b0;
            end
            if (flow_line_change) begin
                flow_pend_reg <= 1'b1;
            end else if (read_status_take && status_snapshot_reg[5:0] == uisl_pkg::CODE_FLOW) begin
                flow_pend_reg <= 1'b0;
            end
        end
    end

    assign enhanced = config_reg[uisl_pkg::CFG_ENHANCED];

    // Priority encoder; the enhanced sources are masked outside enhanced mode.
    always_comb begin
        if (source_enable_reg[uisl_pkg::EN_LINE] && receive_line_condition) begin
            code_next = uisl_pkg::CODE_LINE;
        end else if (source_enable_reg[uisl_pkg::EN_RXDATA] && receive_timeout) begin
            code_next = uisl_pkg::CODE_TIMEOUT;
        end else if (source_enable_reg[uisl_pkg::EN_RXDATA] && receive_data_available) begin
            code_next = uisl_pkg::CODE_RXDATA;
        end else if (source_enable_reg[uisl_pkg::EN_TXEMPTY] && tx_empty_pend_reg) begin
            code_next = uisl_pkg::CODE_TXEMPTY;
        end else if (source_enable_reg[uisl_pkg::EN_MODEM] && modem_change_status) begin
            code_next = uisl_pkg::CODE_MODEM;
        end else if (enhanced && source_enable_reg[uisl_pkg::EN_XOFF] && (xoff_pend_reg || special_pend_reg)) begin
            code_next = uisl_pkg::CODE_XOFF;
        end else if (enhanced && source_enable_reg[uisl_pkg::EN_FLOW] && flow_pend_reg) begin
            code_next = uisl_pkg::CODE_FLOW;
        end else begin
            code_next = uisl_pkg::CODE_NONE;
        end
    end

    // Status byte: FIFO indication above the single reported code.
    assign interrupt_source_status = {{2{config_reg[uisl_pkg::CFG_FIFO_EN]}}, code_next};
    assign irq_out = code_next != uisl_pkg::CODE_NONE;
    assign fifo_enable = config_reg[uisl_pkg::CFG_FIFO_EN];

    // Line format decode for the transmitter and receiver.
    assign divisor_latch_access = line_format_control_reg[uisl_pkg::LFC_DLAB];
    assign tx_serial_out = tx_serial_in & ~line_format_control_reg[uisl_pkg::LFC_BREAK];
    assign parity_enable = line_format_control_reg[uisl_pkg::LFC_PAR_EN];
    assign parity_forced = parity_enable & line_format_control_reg[uisl_pkg::LFC_STICK];
    assign parity_even = parity_enable & ~line_format_control_reg[uisl_pkg::LFC_STICK] &
                         line_format_control_reg[uisl_pkg::LFC_EVEN];
    assign parity_forced_value = parity_forced & ~line_format_control_reg[uisl_pkg::LFC_EVEN];
    assign word_length_bits = uisl_pkg::WLEN_BASE + {2'h0, line_format_control_reg[1:0]};

    // Stop length; the half-bit unit lets 1.5 stop bits be expressed exactly.
    always_comb begin
        if (!line_format_control_reg[uisl_pkg::LFC_STOP]) begin
            stop_half_bits = uisl_pkg::STOP_ONE;
        end else if (line_format_control_reg[1:0] == 2'h0) begin
            stop_half_bits = uisl_pkg::STOP_ONE_HALF;
        end else begin
            stop_half_bits = uisl_pkg::STOP_TWO;
        end
    end

    // Checks kept beside the logic they guard.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_request;
        (read || write) && waitrequest;
    endsequence

    sequence s_thr_load;
        take_write && address == uisl_pkg::OFS_TX_HOLDING && !transmit_holding_empty;
    endsequence

    a_bus_one_wait: assert property (s_request |=> !waitrequest)
        else $error("Bus request not answered after one wait cycle.");
    a_line_top_code: assert property (source_enable_reg[0] && receive_line_condition
        |-> interrupt_source_status[5:0] == 6'h06)
        else $error("Line status not reported first.");
    a_timeout_code: assert property (source_enable_reg[1] && receive_timeout &&
        !(source_enable_reg[0] && receive_line_condition) |-> interrupt_source_status[5:0] == 6'h0C)
        else $error("Time-out code wrong.");
    a_thr_clears: assert property (s_thr_load |=> !tx_empty_pend_reg)
        else $error("Transmit-empty not cleared by holding load.");
    a_xoff_holds: assert property (xoff_pend_reg && !xon_received |=> xoff_pend_reg)
        else $error("Xoff indication dropped without Xon.");
    a_enh_bits_zero: assert property (!enhanced |-> interrupt_source_status[5:4] == 2'h0)
        else $error("Enhanced bits set outside enhanced mode.");
    a_fifo_bits: assert property (interrupt_source_status[7:6] == {2{config_reg[0]}})
        else $error("FIFO indication bits wrong.");
    a_irq_pending: assert property (irq_out == !interrupt_source_status[0])
        else $error("Interrupt pin disagrees with pending bit.");
    a_break_low: assert property (line_format_control_reg[6] |-> !tx_serial_out)
        else $error("Break does not hold the line low.");
    a_stop_half: assert property (line_format_control_reg[2] && line_format_control_reg[1:0] == 2'h0
        |-> stop_half_bits == 3'h3)
        else $error("Stop length wrong for 5-bit words.");
    a_reset_values: assert property (@(posedge clk) $rose(resetn) |->
        line_format_control_reg == 8'h00 && interrupt_source_status == 8'h01)
        else $error("Reset values wrong.");

    // Enabled requests per priority level, rebuilt from the sources and pending latches so that the code checks
    // stand apart from the encoder that they watch.
    logic lvl1_req;
    logic lvl2_req;
    logic lvl3_req;
    logic lvl4_req;
    logic lvl5_req;
    logic lvl6_req;
    logic above_lvl3;
    logic above_lvl5;
    logic any_req;
    logic [7:0] write_low;
    assign lvl1_req = source_enable_reg[uisl_pkg::EN_LINE] & receive_line_condition;
    assign lvl2_req = source_enable_reg[uisl_pkg::EN_RXDATA] & (receive_data_available | receive_timeout);
    assign lvl3_req = source_enable_reg[uisl_pkg::EN_TXEMPTY] & tx_empty_pend_reg;
    assign lvl4_req = source_enable_reg[uisl_pkg::EN_MODEM] & modem_change_status;
    assign lvl5_req = enhanced & source_enable_reg[uisl_pkg::EN_XOFF] & (xoff_pend_reg | special_pend_reg);
    assign lvl6_req = enhanced & source_enable_reg[uisl_pkg::EN_FLOW] & flow_pend_reg;
    assign above_lvl3 = lvl1_req | lvl2_req;
    assign above_lvl5 = above_lvl3 | lvl3_req | lvl4_req;
    assign any_req = above_lvl5 | lvl5_req | lvl6_req;
    assign write_low = writedata[7:0];

    // A status read accepted here whose captured code was transmit-empty, with no new empty event.
    sequence s_txempty_read;
        read_status_take && status_snapshot_reg[5:0] == uisl_pkg::CODE_TXEMPTY && !transmit_holding_empty;
    endsequence

    // A status read accepted here whose captured code was the flow change, with no new change.
    sequence s_flow_read;
        read_status_take && status_snapshot_reg[5:0] == uisl_pkg::CODE_FLOW && !flow_line_change;
    endsequence

    // Accepted writes to the line format and transmit holding registers.
    sequence s_format_write;
        take_write && address == uisl_pkg::OFS_LINE_FORMAT;
    endsequence

    sequence s_holding_write;
        take_write && address == uisl_pkg::OFS_TX_HOLDING;
    endsequence

    // Each lower level shows only while every level above it is quiet.
    a_rxdata_code: assert property (lvl2_req && !receive_timeout && !lvl1_req
        |-> interrupt_source_status[5:0] == 6'h04)
        else $error("Data available code wrong.");
    a_txempty_code: assert property (lvl3_req && !above_lvl3 |-> interrupt_source_status[5:0] == 6'h02)
        else $error("Transmit-empty code wrong.");
    a_modem_code: assert property (lvl4_req && !above_lvl3 && !lvl3_req
        |-> interrupt_source_status[5:0] == 6'h00)
        else $error("Modem change code wrong.");
    a_xoff_code: assert property (lvl5_req && !above_lvl5 |-> interrupt_source_status[5:0] == 6'h10)
        else $error("Xoff or special character code wrong.");
    a_flow_code: assert property (lvl6_req && !above_lvl5 && !lvl5_req
        |-> interrupt_source_status[5:0] == 6'h20)
        else $error("Flow change code wrong.");
    a_none_idle: assert property (!any_req |-> interrupt_source_status[5:0] == 6'h01)
        else $error("Idle status code wrong.");

    // Servicing clears only the source that was read out; the Xoff latch waits for Xon instead.
    a_read_clears_tx: assert property (s_txempty_read |=> !tx_empty_pend_reg)
        else $error("Transmit-empty not cleared by status read.");
    a_flow_clears: assert property (s_flow_read |=> !flow_pend_reg)
        else $error("Flow change not cleared by status read.");
    a_xon_clears: assert property (xon_received && !xoff_detected |=> !xoff_pend_reg)
        else $error("Xoff indication kept after Xon.");

    // Bus writes land at the accepting edge, and a holding load gives exactly one strobe.
    a_format_lands: assert property (s_format_write |=> line_format_control_reg == $past(write_low))
        else $error("Line format write did not land.");
    a_load_strobe: assert property (s_holding_write |=> transmit_holding_load ##1 !transmit_holding_load)
        else $error("Holding load strobe not one cycle.");

    // Line format decode seen by the transmitter and receiver.
    a_latch_access: assert property (divisor_latch_access == line_format_control_reg[7])
        else $error("Latch access does not follow format bit 7.");
    a_word_eight: assert property (line_format_control_reg[1:0] == 2'h3 |-> word_length_bits == 4'h8)
        else $error("Word length wrong for 8-bit words.");
    a_stop_one: assert property (!line_format_control_reg[2] |-> stop_half_bits == 3'h2)
        else $error("Single stop bit wrong.");
    a_parity_none: assert property (!line_format_control_reg[3] |-> !parity_enable && !parity_even &&
        !parity_forced && !parity_forced_value)
        else $error("Parity active while disabled.");
    a_parity_zero: assert property (line_format_control_reg[5:3] == 3'h7 |-> parity_forced &&
        !parity_forced_value && !parity_even)
        else $error("Forced zero parity wrong.");
    a_parity_odd: assert property (line_format_control_reg[5:3] == 3'h1 |-> parity_enable &&
        !parity_even && !parity_forced)
        else $error("Odd parity wrong.");
endmodule

//--- rtl/uisl_pkg.sv
// Package of register map, field positions, reset values and interrupt codes for the status and line format block.
package uisl_pkg;
    // Register bus geometry.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    // Byte addresses of the registers.
    localparam logic [4:0] OFS_INT_STATUS = 5'h00;
    localparam logic [4:0] OFS_LINE_FORMAT = 5'h04;
    localparam logic [4:0] OFS_CONFIG = 5'h08;
    localparam logic [4:0] OFS_SOURCE_ENABLE = 5'h0C;
    localparam logic [4:0] OFS_TX_HOLDING = 5'h10;
    // Line format control fields.
    localparam int LFC_DLAB = 7;
    localparam int LFC_BREAK = 6;
    localparam int LFC_STICK = 5;
    localparam int LFC_EVEN = 4;
    localparam int LFC_PAR_EN = 3;
    localparam int LFC_STOP = 2;
    localparam int LFC_WLEN_HI = 1;
    localparam int LFC_WLEN_LO = 0;
    localparam logic [7:0] LFC_RESET = 8'h00;
    // Configuration fields.
    localparam int CFG_FIFO_EN = 0;
    localparam int CFG_ENHANCED = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    // Source enable fields.
    localparam int EN_LINE = 0;
    localparam int EN_RXDATA = 1;
    localparam int EN_TXEMPTY = 2;
    localparam int EN_MODEM = 3;
    localparam int EN_XOFF = 4;
    localparam int EN_FLOW = 5;
    localparam int EN_W = 6;
    localparam logic [5:0] EN_RESET = 6'h00;
    // Interrupt status fields.
    localparam int IS_FIFO_HI = 7;
    localparam int IS_FIFO_LO = 6;
    localparam int IS_ENH_HI = 5;
    localparam int IS_ENH_LO = 4;
    // Six-bit source codes, bit 0 low means pending.
    typedef enum logic [5:0] {
        CODE_LINE = 6'h06,
        CODE_RXDATA = 6'h04,
        CODE_TIMEOUT = 6'h0C,
        CODE_TXEMPTY = 6'h02,
        CODE_MODEM = 6'h00,
        CODE_XOFF = 6'h10,
        CODE_FLOW = 6'h20,
        CODE_NONE = 6'h01
    } uisl_code_t;
    // Stop length in half-bit units and base word length.
    localparam logic [2:0] STOP_ONE = 3'h2;
    localparam logic [2:0] STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_TWO = 3'h4;
    localparam logic [3:0] WLEN_BASE = 4'h5;
    // Bus answer delay in cycles after the request is first seen.
    localparam int BUS_WAIT_CYCLES = 1;
endpackage

//--- tb/uisl_host_model.sv
// Host model that masters the Avalon-MM register bus of the status and line format block.
`timescale 1ns/10ps
module uisl_host_model (
    // Clock.
    input wire logic clk,
    // Bus answer from the slave.
    input wire logic waitrequest,
    input wire logic [uisl_pkg::DATA_W-1:0] readdata,
    // Bus request to the slave.
    output logic [uisl_pkg::ADDR_W-1:0] address,
    output logic read,
    output logic write,
    output logic [uisl_pkg::DATA_W-1:0] writedata
);
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
    end

    // One transfer; the request is held until the rising edge where waitrequest is low, so the slave may stall.
    task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q,
                        output bit ok);
        int n;
        ok = 1'b0;
        q = '0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !we;
        write <= we;
        // Waitrequest and read data are read before this edge's updates land, as the slave sees them.
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) begin
                ok = 1'b1;
                q = readdata;
                break;
            end
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

//--- tb/uisl_top_tb_top.sv
// Self-checking testbench of the status and line format block.
`timescale 1ns/10ps
module uisl_top_tb_top;
    logic clk, resetn, tx_in, waitrequest, irq_out, dla, pen, peven, pforced, pfval, fifo_en, th_load, tx_out;
    logic rd, wr;
    logic [4:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] lv, wlen;
    logic [4:0] pls;
    logic [2:0] stop;
    logic [7:0] th_data;
    int n_errors, compares;
    int i;

    uisl_top uisl_top_inst (.clk(clk), .resetn(resetn), .address(address), .read(rd), .write(wr),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .receive_line_condition(lv[0]), .receive_data_available(lv[1]), .receive_timeout(lv[2]),
        .transmit_holding_empty(pls[0]), .modem_change_status(lv[3]), .xoff_detected(pls[1]),
        .xon_received(pls[2]), .special_char_detected(pls[3]), .flow_line_change(pls[4]),
        .tx_serial_in(tx_in), .tx_serial_out(tx_out), .divisor_latch_access(dla), .word_length_bits(wlen),
        .stop_half_bits(stop), .parity_enable(pen), .parity_even(peven), .parity_forced(pforced),
        .parity_forced_value(pfval), .fifo_enable(fifo_en), .transmit_holding_load(th_load),
        .transmit_holding_data(th_data), .irq_out(irq_out));

    uisl_host_model uisl_host_model_inst (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(rd), .write(wr), .writedata(writedata));

    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // A transfer that never gets its answer is a mismatch and ends the run.
    task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
        bit ok;
        uisl_host_model_inst.xfer(we, a, d, q, ok);
        if (!ok) begin
            n_errors++;
            $display("unexpected waitrequest: expected 0, seen 1");
            test_done();
        end
    endtask

    // Reads the status register; the pin is checked first, mid-cycle where it has settled.
    task automatic st(input logic [7:0] exp);
        @(negedge clk);
        chk("irq_out", {31'h0, ~exp[0]}, {31'h0, irq_out});
        bus(1'b0, uisl_pkg::OFS_INT_STATUS, 32'h0);
        chk("status", {24'h0, exp}, q);
    endtask

    task automatic pulse(input logic [4:0] v);
        pls <= v;
        @(posedge clk);
        pls <= 5'h00;
    endtask

    initial begin
        resetn = 1'b0;
        tx_in = 1'b1;
        lv = 4'h0;
        pls = 5'h00;
        n_errors = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        st(8'h01);
        bus(1'b0, uisl_pkg::OFS_LINE_FORMAT, 32'h0);
        chk("format", 32'h0, q);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, uisl_pkg::OFS_INT_STATUS, 32'hFF);
        st(8'h01);
        bus(1'b1, uisl_pkg::OFS_SOURCE_ENABLE, 32'h3F);
        bus(1'b1, uisl_pkg::OFS_CONFIG, 32'h3);
        // Every source but the special character pending at once; each read shows one source and servicing uncovers the next.
        lv <= 4'hF;
        pulse(5'h13);
        st(8'hC6);
        lv[0] <= 1'b0;
        st(8'hCC);
        lv[2] <= 1'b0;
        st(8'hC4);
        lv[1] <= 1'b0;
        st(8'hC2);
        st(8'hC0);
        lv[3] <= 1'b0;
        st(8'hD0);
        st(8'hD0);
        pulse(5'h04);
        st(8'hE0);
        st(8'hC1);
        // Loading the holding register clears transmit-empty without a status read.
        pulse(5'h01);
        @(negedge clk);
        chk("irq_out", 32'h1, {31'h0, irq_out});
        bus(1'b1, uisl_pkg::OFS_TX_HOLDING, 32'hA5);
        @(negedge clk);
        chk("load", 32'h1A5, {23'h0, th_load, th_data});
        st(8'hC1);
        // Enhanced mode off: the top two code bits stay zero.
        bus(1'b1, uisl_pkg::OFS_CONFIG, 32'h1);
        pulse(5'h10);
        bus(1'b0, uisl_pkg::OFS_INT_STATUS, 32'h0);
        chk("enhanced bits", 32'h0, {30'h0, q[5:4]});
        // The flow latch kept its event while masked and shows once enhanced mode is back.
        bus(1'b1, uisl_pkg::OFS_CONFIG, 32'h2);
        st(8'h20);
        st(8'h01);
        chk("fifo_enable", 32'h0, {31'h0, fifo_en});
        // Every word length, stop and parity setting.
        for (i = 0; i < 64; i++) begin
            bus(1'b1, uisl_pkg::OFS_LINE_FORMAT, i);
            @(negedge clk);
            chk("word_length", 5 + i[1:0], {28'h0, wlen});
            chk("stop_half", i[2] ? (i[1:0] == 0 ? 3 : 4) : 2, {29'h0, stop});
            chk("parity", {i[3], i[3] & i[4] & ~i[5], i[3] & i[5], i[3] & i[5] & ~i[4]},
                {28'h0, pen, peven, pforced, pfval});
            bus(1'b0, uisl_pkg::OFS_LINE_FORMAT, 32'h0);
            chk("format", i, q);
        end
        bus(1'b1, uisl_pkg::OFS_LINE_FORMAT, 32'hC0);
        @(negedge clk);
        chk("latch access", 32'h1, {31'h0, dla});
        chk("break", 32'h0, {31'h0, tx_out});
        bus(1'b1, uisl_pkg::OFS_LINE_FORMAT, 32'h00);
        @(negedge clk);
        chk("break off", 32'h3, {30'h0, tx_out, ~dla});
        @(posedge clk);
        tx_in <= 1'b0;
        @(negedge clk);
        chk("serial", 32'h0, {31'h0, tx_out});
        test_done();
    end
endmodule
